/* File: logic/falling_irq_pkg.sv */
// Shared constants and types for the falling-edge interrupt enable block
package falling_irq_pkg;

  // Geometry: each register pair covers an even and an odd 16-pin bank
  localparam int          NUM_PAIRS   = 3;
  localparam int          PAIR_W      = 32;
  localparam int          BANK_W      = 16;
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;

  // Byte offsets on the register bus
  localparam logic [7:0]  ARM_OFS     = 8'h00;
  localparam logic [7:0]  DISARM_OFS  = 8'h04;
  localparam logic [7:0]  PAIR_STRIDE = 8'h08;
  localparam logic [7:0]  STAT_OFS    = 8'h18;
  localparam logic [7:0]  MASK_OFS    = 8'h24;
  localparam logic [7:0]  WORD_STRIDE = 8'h04;

  // Reset values
  localparam logic [31:0] ENABLE_RST  = 32'h00000000;
  localparam logic [31:0] PENDING_RST = 32'h00000000;
  localparam logic [31:0] MASK_RST    = 32'h00000000;

  // Bus responses
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Write and read channel sequencers
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESPOND = 2'b10
  } wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_DATA = 2'b10
  } rd_state_t;

endpackage

/* File: logic/sync2.sv */
// Two-stage synchroniser for a vector of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 32
) (
  input  wire logic         clk,      // Core clock
  input  wire logic         rst,      // Asynchronous reset, high
  input  wire logic         ce,       // Clock enable
  input  wire logic [W-1:0] async_in, // Raw pin levels
  output logic      [W-1:0] sync_out  // Levels safe to use
);

  logic [W-1:0] meta_q;

  // Only the second stage is read outside; the first may be metastable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (ce) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule
`default_nettype wire

/* File: logic/falling_edge_bank.sv */
// Per-pin falling-edge enable, edge detector and pending flag for one pair
`timescale 1ns/1ps
`default_nettype none
module falling_edge_bank #(
  parameter int W = 32
) (
  input  wire logic         clk,        // Core clock
  input  wire logic         rst,        // Asynchronous reset, high
  input  wire logic         ce,         // Clock enable
  input  wire logic [W-1:0] pin_level,  // Synchronised pin levels
  input  wire logic [W-1:0] arm_bits,   // Ones written to the arm register
  input  wire logic [W-1:0] disarm_bits,// Ones written to the disarm register
  input  wire logic [W-1:0] clear_bits, // Ones written to the status register
  output logic      [W-1:0] enable_q,   // Shared enable flag per pin
  output logic      [W-1:0] pending_q   // Sticky pending event per pin
);

  logic [W-1:0] prev_q;
  logic [W-1:0] fall_event;

  // Reset of prev to zero means no falling edge can be seen at release
  assign fall_event = prev_q & ~pin_level & enable_q; // [R1]

  // Previous level for edge detection
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= '0;
    end else if (ce) begin
      prev_q <= pin_level;
    end
  end

  // One flag, two writers; a zero written to either leaves it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_q <= W'(falling_irq_pkg::ENABLE_RST); // [R9]
    end else if (ce) begin
      enable_q <= (enable_q | arm_bits) & ~disarm_bits; // [R2] [R7] [R11]
    end
  end

  // A new event in the clearing cycle wins over the clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pending_q <= W'(falling_irq_pkg::PENDING_RST);
    end else if (ce) begin
      pending_q <= (pending_q & ~clear_bits) | fall_event; // [R10]
    end
  end

endmodule
`default_nettype wire

/* File: logic/gpio_falling_irq.sv */
// Falling-edge interrupt enable block with AXI4-Lite registers
//
// Summary of operation
// [R1] Each pin keeps a falling-edge enable flag
// [R2] Arm-register zeros leave enables; ones arm
// [R3] Arm-register reads return the live enable flags
// [R4] Low half even bank, high half odd
// [R5] Pair zero bit k is pin k
// [R6] Pair one arm bit k is pin 32+k
// [R7] Disarm-register ones disarm the pin's flag
// [R8] Pair one disarm bit k is pin 32+k
// [R9] Arm and disarm registers reset to zero
// [R10] Armed edge sets status; write one clears
// [R11] One shared flag; disarm beats arm
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module gpio_falling_irq #(
  parameter int NUM_PAIRS = falling_irq_pkg::NUM_PAIRS
) (
  input  wire logic        CORE_CLK,  // Core clock, 50 MHz
  input  wire logic        RST,       // Asynchronous reset, high
  input  wire logic        CE,        // Clock enable, freezes all state
  input  wire logic [NUM_PAIRS*32-1:0] PIN_IN, // Pin levels, asynchronous
  input  wire logic [7:0]  AWADDR,    // Write address
  input  wire logic        AWVALID,   // Write address valid
  output logic             AWREADY,   // Write address ready
  input  wire logic [31:0] WDATA,     // Write data
  input  wire logic [3:0]  WSTRB,     // Write byte strobes
  input  wire logic        WVALID,    // Write data valid
  output logic             WREADY,    // Write data ready
  output logic [1:0]       BRESP,     // Write response
  output logic             BVALID,    // Write response valid
  input  wire logic        BREADY,    // Write response ready
  input  wire logic [7:0]  ARADDR,    // Read address
  input  wire logic        ARVALID,   // Read address valid
  output logic             ARREADY,   // Read address ready
  output logic [31:0]      RDATA,     // Read data
  output logic [1:0]       RRESP,     // Read response
  output logic             RVALID,    // Read data valid
  input  wire logic        RREADY,    // Read data ready
  output logic             IRQ        // Level interrupt, high
);

  localparam int PW   = falling_irq_pkg::PAIR_W;
  localparam int PINS = NUM_PAIRS * PW;

  // Register addresses for pair or word index p
  function automatic logic [7:0] arm_addr(input int p);
    return 8'(int'(falling_irq_pkg::ARM_OFS)
              + p * int'(falling_irq_pkg::PAIR_STRIDE));
  endfunction

  function automatic logic [7:0] disarm_addr(input int p);
    return 8'(int'(falling_irq_pkg::DISARM_OFS)
              + p * int'(falling_irq_pkg::PAIR_STRIDE));
  endfunction

  function automatic logic [7:0] stat_addr(input int p);
    return 8'(int'(falling_irq_pkg::STAT_OFS)
              + p * int'(falling_irq_pkg::WORD_STRIDE));
  endfunction

  function automatic logic [7:0] mask_addr(input int p);
    return 8'(int'(falling_irq_pkg::MASK_OFS)
              + p * int'(falling_irq_pkg::WORD_STRIDE));
  endfunction

  // One sequencer per direction, so a read never waits on a write
  falling_irq_pkg::wr_state_t wr_state_q;
  falling_irq_pkg::rd_state_t rd_state_q;

  logic            aw_held_q;
  logic            w_held_q;
  logic [7:0]      wr_addr_q;
  logic [31:0]     wr_data_q;
  logic [3:0]      wr_strb_q;
  logic [1:0]      bresp_q;
  logic [31:0]     rdata_q;
  logic [1:0]      rresp_q;
  logic            irq_q;

  logic            wr_fire;
  logic            wr_hit;
  logic [31:0]     wr_lanes;
  logic [31:0]     wr_bits;
  logic [31:0]     rd_word;
  logic            rd_hit;
  logic [PINS-1:0] pin_sync;

  logic [PW-1:0]   enable_w  [NUM_PAIRS];
  logic [PW-1:0]   pending_w [NUM_PAIRS];
  logic [PW-1:0]   mask_q    [NUM_PAIRS];

  // Pins come from outside the clock domain
  sync2 #(
    .W (PINS)
  ) u_pin_sync (
    .clk      (CORE_CLK),
    .rst      (RST),
    .ce       (CE),
    .async_in (PIN_IN),
    .sync_out (pin_sync)
  );

  // Handshake outputs; nothing is taken while the clock enable is low
  // Readies drop with CE so no beat is lost while state is frozen
  assign AWREADY = CE && !aw_held_q
                   && (wr_state_q == falling_irq_pkg::WR_COLLECT);
  assign WREADY  = CE && !w_held_q
                   && (wr_state_q == falling_irq_pkg::WR_COLLECT);
  assign BVALID  = (wr_state_q == falling_irq_pkg::WR_RESPOND);
  assign BRESP   = bresp_q;
  assign ARREADY = CE && (rd_state_q == falling_irq_pkg::RD_IDLE);
  assign RVALID  = (rd_state_q == falling_irq_pkg::RD_DATA);
  assign RDATA   = rdata_q;
  assign RRESP   = rresp_q;
  assign IRQ     = irq_q;

  // Write acts once both address and data are held
  assign wr_fire = CE && aw_held_q && w_held_q
                   && (wr_state_q == falling_irq_pkg::WR_COLLECT);

  // Lanes without a strobe carry zeros, so they neither arm nor clear
  // The mask too keeps its old byte there, by masking lanes as a plain register would
  assign wr_lanes = {{8{wr_strb_q[3]}}, {8{wr_strb_q[2]}},
                     {8{wr_strb_q[1]}}, {8{wr_strb_q[0]}}};
  assign wr_bits  = wr_data_q & wr_lanes;

  // Address and data may arrive in either order
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      aw_held_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else if (CE) begin
      if (AWVALID && AWREADY) begin
        aw_held_q <= 1'b1;
        wr_addr_q <= AWADDR;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
    end
  end

  // Write data holding register
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      w_held_q  <= 1'b0;
      wr_data_q <= 32'h00000000;
      wr_strb_q <= 4'h0;
    end else if (CE) begin
      if (WVALID && WREADY) begin
        w_held_q  <= 1'b1;
        wr_data_q <= WDATA;
        wr_strb_q <= WSTRB;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write address decode; unmapped words answer with an error
  // The decode uses the held address, so it is stable while it fires
  always_comb begin
    wr_hit = 1'b0;
    for (int p = 0; p < NUM_PAIRS; p++) begin
      if (wr_addr_q == arm_addr(p) || wr_addr_q == disarm_addr(p)
          || wr_addr_q == stat_addr(p) || wr_addr_q == mask_addr(p)) begin
        wr_hit = 1'b1;
      end
    end
  end

  // Write response sequencer
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      wr_state_q <= falling_irq_pkg::WR_COLLECT;
      bresp_q    <= falling_irq_pkg::RESP_OKAY;
    end else if (CE) begin
      case (wr_state_q)
        falling_irq_pkg::WR_COLLECT: begin
          if (wr_fire) begin
            wr_state_q <= falling_irq_pkg::WR_RESPOND;
            bresp_q    <= wr_hit ? falling_irq_pkg::RESP_OKAY
                                 : falling_irq_pkg::RESP_SLVERR;
          end
        end
        falling_irq_pkg::WR_RESPOND: begin
          if (BREADY) begin
            wr_state_q <= falling_irq_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state_q <= falling_irq_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  // One bank per register pair; pin index is pair*32 + bit
  // Status and mask share the pair index, so one loop serves all
  for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pair
    logic [PW-1:0] arm_bits;
    logic [PW-1:0] disarm_bits;
    logic [PW-1:0] clear_bits;

    assign arm_bits    = (wr_fire && wr_addr_q == arm_addr(p))
                         ? wr_bits : '0; // [R2]
    assign disarm_bits = (wr_fire && wr_addr_q == disarm_addr(p))
                         ? wr_bits : '0; // [R7]
    assign clear_bits  = (wr_fire && wr_addr_q == stat_addr(p))
                         ? wr_bits : '0; // [R10]

    // Bits 15-0 even bank, 31-16 the odd bank above it
    falling_edge_bank #(
      .W (PW)
    ) u_bank (
      .clk         (CORE_CLK),
      .rst         (RST),
      .ce          (CE),
      .pin_level   (pin_sync[p*PW +: PW]), // [R4] [R5] [R6] [R8]
      .arm_bits    (arm_bits),
      .disarm_bits (disarm_bits),
      .clear_bits  (clear_bits),
      .enable_q    (enable_w[p]),
      .pending_q   (pending_w[p])
    );

    // Mask honours byte strobes as a plain read-write register
    always_ff @(posedge CORE_CLK or posedge RST) begin
      if (RST) begin
        mask_q[p] <= falling_irq_pkg::MASK_RST;
      end else if (CE && wr_fire && wr_addr_q == mask_addr(p)) begin
        mask_q[p] <= (mask_q[p] & ~wr_lanes) | wr_bits;
      end
    end
  end

  // Read decode straight from the address channel
  // Decoding before the address is taken costs a wide mux on the
  // input path but saves a cycle of read latency
  always_comb begin
    rd_word = 32'h00000000;
    rd_hit  = 1'b0;
    for (int p = 0; p < NUM_PAIRS; p++) begin
      // Both enable registers show the shared live flags
      if (ARADDR == arm_addr(p) || ARADDR == disarm_addr(p)) begin
        rd_word = enable_w[p]; // [R3]
        rd_hit  = 1'b1;
      end
      if (ARADDR == stat_addr(p)) begin
        rd_word = pending_w[p];
        rd_hit  = 1'b1;
      end
      if (ARADDR == mask_addr(p)) begin
        rd_word = mask_q[p];
        rd_hit  = 1'b1;
      end
    end
  end

  // Read sequencer; data held until the master takes it
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      rd_state_q <= falling_irq_pkg::RD_IDLE;
      rdata_q    <= 32'h00000000;
      rresp_q    <= falling_irq_pkg::RESP_OKAY;
    end else if (CE) begin
      case (rd_state_q)
        falling_irq_pkg::RD_IDLE: begin
          if (ARVALID) begin
            rd_state_q <= falling_irq_pkg::RD_DATA;
            rdata_q    <= rd_word;
            rresp_q    <= rd_hit ? falling_irq_pkg::RESP_OKAY
                                 : falling_irq_pkg::RESP_SLVERR;
          end
        end
        falling_irq_pkg::RD_DATA: begin
          if (RREADY) begin
            rd_state_q <= falling_irq_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_q <= falling_irq_pkg::RD_IDLE;
        end
      endcase
    end
  end

  // Registered interrupt: one cycle late, but glitch-free at the pin
  // A masked pending bit stays readable in status but off the pin
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      irq_q <= 1'b0;
    end else if (CE) begin
      irq_q <= 1'b0;
      for (int p = 0; p < NUM_PAIRS; p++) begin
        if (|(pending_w[p] & mask_q[p])) begin
          irq_q <= 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

/* File: tb/gpio_falling_irq_checker.sv */
// Register bus checks for the falling-edge interrupt block
`timescale 1ns/1ps
`default_nettype none
module gpio_falling_irq_checker (
  input wire logic        CORE_CLK, // Clock
  input wire logic        RST,      // Reset
  input wire logic        CE,       // Enable
  input wire logic        AWVALID,  // Aw valid
  input wire logic        AWREADY,  // Aw ready
  input wire logic        WVALID,   // W valid
  input wire logic        WREADY,   // W ready
  input wire logic [1:0]  BRESP,    // B code
  input wire logic        BVALID,   // B valid
  input wire logic        BREADY,   // B ready
  input wire logic [7:0]  ARADDR,   // Ar address
  input wire logic        ARVALID,  // Ar valid
  input wire logic        ARREADY,  // Ar ready
  input wire logic [31:0] RDATA,    // R data
  input wire logic [1:0]  RRESP,    // R code
  input wire logic        RVALID,   // R valid
  input wire logic        RREADY    // R ready
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (RST);

  // Both write channels taken together answer two edges later
  a_write_answer: assert property (
    AWVALID && AWREADY && WVALID && WREADY |-> ##2 BVALID)
    else $error("write response late");
  // No new write is accepted while a response waits
  a_write_busy: assert property (
    BVALID |-> !AWREADY && !WREADY)
    else $error("write taken while answering");
  a_resp_hold: assert property (
    BVALID && !BREADY |=> BVALID && $stable(BRESP))
    else $error("write response dropped");
  a_read_answer: assert property (
    ARVALID && ARREADY |=> RVALID)
    else $error("read data late");
  a_read_hold: assert property (
    RVALID && !RREADY |=> RVALID && $stable(RDATA))
    else $error("read data changed");
  a_read_busy: assert property (
    RVALID |-> !ARREADY)
    else $error("read taken while answering");
  // Addresses past the map answer an error with zero data
  a_unmapped_read: assert property (
    ARVALID && ARREADY && ARADDR > 8'h2C |=>
      RRESP == falling_irq_pkg::RESP_SLVERR && RDATA == 32'h0)
    else $error("unmapped read not refused");
  a_ce_freeze: assert property (
    !CE |-> !(AWREADY || WREADY || ARREADY))
    else $error("ready while frozen");
endmodule

bind gpio_falling_irq gpio_falling_irq_checker chk_inst (
  .CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .AWVALID(AWVALID),
  .AWREADY(AWREADY), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
  .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
  .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
  .RREADY(RREADY));
`default_nettype wire

/* File: tb/pin_source.sv */
// Model of the external pins that the block watches for edges
`timescale 1ns/1ps
`default_nettype none
module pin_source #(
  parameter int W = 96
) (
  input  wire logic         clk,  // Stepping reference
  input  wire logic [W-1:0] fall, // Pins to pull low
  input  wire logic [W-1:0] lift, // Pins to let go high
  output logic      [W-1:0] level // Pin levels
);
  // Pins idle high; changes land on the falling clock, off the
  // sampling edge, as an unrelated source would
  initial level = {W{1'b1}};
  always @(negedge clk) begin
    level <= (level & ~fall) | lift;
  end
endmodule
`default_nettype wire

/* File: tb/gpio_falling_irq_tb.sv */
// Self-checking bench for the falling-edge interrupt block
`timescale 1ns/1ps
`default_nettype none
module gpio_falling_irq_tb;
  logic        CORE_CLK = 1'b0;
  logic        RST = 1'b1;
  logic        CE = 1'b1;
  logic        AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic        ARVALID = 1'b0, RREADY = 1'b0;
  logic [7:0]  AWADDR = 8'h00, ARADDR = 8'h00;
  logic [31:0] WDATA = 32'h0;
  logic [3:0]  WSTRB = 4'hF;
  logic [95:0] fall = 96'h0, lift = 96'h0;
  logic [95:0] PIN_IN;
  logic        AWREADY, WREADY, BVALID, ARREADY, RVALID, IRQ;
  logic [1:0]  BRESP, RRESP;
  logic [31:0] RDATA;
  int          fails = 0;
  int          check_count = 0;

  always #10 CORE_CLK = ~CORE_CLK;

  pin_source pin_source_inst (.clk(CORE_CLK), .fall(fall), .lift(lift),
    .level(PIN_IN));

  gpio_falling_irq gpio_falling_irq_inst (
    .CORE_CLK(CORE_CLK), .RST(RST), .CE(CE), .PIN_IN(PIN_IN),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .IRQ(IRQ));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Handshakes are judged at the negedge, where the values equal those
  // the next rising edge samples, so no race with the design's flops
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    logic aw, w, v, b;
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge CORE_CLK);
      aw = AWVALID && AWREADY;
      w = WVALID && WREADY;
      v = BVALID;
      b = BVALID && BREADY;
      r = BRESP;
      @(posedge CORE_CLK);
      if (aw) AWVALID <= 1'b0;
      if (w) WVALID <= 1'b0;
      BREADY <= v && !b;
    end
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    logic ar, v, h;
    ARADDR <= a;
    ARVALID <= 1'b1;
    h = 1'b0;
    while (!h) begin
      @(negedge CORE_CLK);
      ar = ARVALID && ARREADY;
      v = RVALID;
      h = RVALID && RREADY;
      d = RDATA;
      r = RRESP;
      @(posedge CORE_CLK);
      if (ar) ARVALID <= 1'b0;
      RREADY <= v && !h;
    end
  endtask

  task automatic wrc(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, 32'h0);
  endtask

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, 32'h0);
  endtask

  task automatic irq_chk(input logic e);
    @(negedge CORE_CLK);
    chk({31'h0, IRQ}, {31'h0, e});
    @(posedge CORE_CLK);
  endtask

  task test_done;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // Whole run needs under two hundred cycles; this bound cuts a hang
  initial begin
    repeat (3000) @(posedge CORE_CLK);
    fails++;
    $display("unexpected at %0t: run hung", $time);
    test_done;
  end

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    repeat (3) @(posedge CORE_CLK);
    RST <= 1'b0;
    @(posedge CORE_CLK);
    for (int a = 0; a < 48; a += 4) begin
      rc(8'(a), 32'h0);
    end
    $display("test reset values done");
    // Pair zero low bits, pair one both halves, pair two top bit
    wrc(8'h00, 32'h00008021);
    wrc(8'h00, 32'h00000000);
    rc(8'h00, 32'h00008021);
    rc(8'h04, 32'h00008021);
    wrc(8'h04, 32'h00000001);
    rc(8'h00, 32'h00008020);
    rc(8'h04, 32'h00008020);
    wrc(8'h08, 32'h00010300);
    wrc(8'h0C, 32'h00010200);
    rc(8'h0C, 32'h00000100);
    wrc(8'h10, 32'h80000000);
    wrc(8'h24, 32'h00000020);
    $display("test enables done");
    // Idle freeze, then armed, disarmed and unarmed pins fall together
    CE <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    CE <= 1'b1;
    fall <= 96'h80000000_00010300_00000061;
    @(posedge CORE_CLK);
    fall <= 96'h0;
    repeat (6) @(posedge CORE_CLK);
    irq_chk(1'b1);
    rc(8'h18, 32'h00000020);
    rc(8'h1C, 32'h00000100);
    rc(8'h20, 32'h80000000);
    wrc(8'h18, 32'h00000000);
    rc(8'h18, 32'h00000020);
    wrc(8'h18, 32'h00000020);
    rc(8'h18, 32'h00000000);
    repeat (2) @(posedge CORE_CLK);
    irq_chk(1'b0);
    // Rising edges never count; a disarmed pin's fall is ignored
    lift <= 96'h61;
    @(posedge CORE_CLK);
    lift <= 96'h0;
    repeat (6) @(posedge CORE_CLK);
    rc(8'h18, 32'h00000000);
    wrc(8'h04, 32'h00000020);
    fall <= 96'h60;
    @(posedge CORE_CLK);
    fall <= 96'h0;
    repeat (6) @(posedge CORE_CLK);
    rc(8'h18, 32'h00000000);
    irq_chk(1'b0);
    $display("test edge events done");
    rd(8'h30, d, r);
    chk(d, 32'h0);
    chk({30'h0, r}, 32'h2);
    wr(8'h30, 32'hFFFFFFFF, r);
    chk({30'h0, r}, 32'h2);
    rc(8'h00, 32'h00008000);
    $display("test unmapped done");
    // Lanes without a strobe carry zeros and arm nothing
    WSTRB <= 4'h4;
    wrc(8'h00, 32'hFFFF0000);
    WSTRB <= 4'hF;
    rc(8'h00, 32'h00FF8000);
    $display("test strobes done");
    test_done;
  end
endmodule
`default_nettype wire
